/* core/dsps_cfg.svh */
// Constants for the dual-slope phase sequencer host controller
`ifndef DSPS_CFG_SVH
`define DSPS_CFG_SVH

// Width of the phase and rundown timer, sized for the longest integration period
`define DSPS_CNT_W      24
// Host clock period in nanoseconds
`define DSPS_CLK_NS     25
// Nanoseconds in one millisecond
`define DSPS_NS_PER_MS  1000000
// Default fixed integration period in milliseconds
`define DSPS_INT_MS     33
// Rundown ceiling as a multiple of the integration count
`define DSPS_RUN_MULT   2
// Cycles between the comparator pin and the falling-edge strobe
`define DSPS_SYNC_LAT   2

// Phase codes on the two control lines, line one in bit 1, line two in bit 0
`define DSPS_CODE_NULL  2'h1
`define DSPS_CODE_INT   2'h2
`define DSPS_CODE_RUN   2'h3
`define DSPS_CODE_RES   2'h0

`endif

/* core/dsps_pkg.sv */
// Types shared by the dual-slope phase sequencer host controller
`include "dsps_cfg.svh"

package dsps_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_NULL,
    ST_INT,
    ST_RUN,
    ST_RES
  } dsps_state_t;

  // The two unlatched control lines toward the converter
  typedef struct packed {
    logic lineA;
    logic lineB;
  } dsps_phase_t;

  // One finished conversion
  typedef struct packed {
    logic                   sign;
    logic                   overRange;
    logic [`DSPS_CNT_W-1:0] magnitude;
  } dsps_result_t;

endpackage

/* core/dsps_sync.sv */
// Two-flop synchroniser for one asynchronous input level
module dsps_sync (
  input  wire logic clk,
  input  wire logic rstSyncN,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic metaReg;  // First stage, read only by the second stage
  logic syncReg;  // Second stage, safe for logic
  logic metaNext;
  logic syncNext;

  // Shift the level one stage per clock
  always_comb begin
    metaNext = asyncIn;
    syncNext = metaReg;
  end

  // Stages reset high, the comparator's settled level after residue clearing
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      metaReg <= 1'b1;
      syncReg <= 1'b1;
    end else begin
      metaReg <= metaNext;
      syncReg <= syncNext;
    end
  end

  assign syncOut = syncReg;

endmodule

/* core/dsps_cnt.sv */
// Saturating up-counter used to time every phase
`include "dsps_cfg.svh"

module dsps_cnt (
  input  wire logic                   clk,
  input  wire logic                   rstSyncN,
  input  wire logic                   clear,
  input  wire logic                   enable,
  output logic [`DSPS_CNT_W-1:0]      count
);

  logic [`DSPS_CNT_W-1:0] countReg;   // Cycles in the present phase
  logic [`DSPS_CNT_W-1:0] countNext;

  // Clear wins; saturation keeps a stuck phase from wrapping to a short count
  always_comb begin
    countNext = countReg;
    if (clear) begin
      countNext = '0;
    end else if (enable && (countReg != '1)) begin
      countNext = countReg + `DSPS_CNT_W'(1);
    end
  end

  // Register the count
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      countReg <= '0;
    end else begin
      countReg <= countNext;
    end
  end

  assign count = countReg;

endmodule

/* core/dsps_sequencer.sv */
// Host controller that sequences a dual-slope converter front end through its four phases
`include "dsps_cfg.svh"

// Overview of operation
// - Phases run null, integrate, rundown, residue.
// - Keep comparator level at integration end: sign.
// - Ignore early integration comparator readings.
// - Rundown time counted by host is magnitude.
// - Rundown follows integration directly, ends at crossing.
// - Residue clearing always follows rundown.
// - Hold residue clearing until comparator high.
// - Ignore comparator during offset nulling.
// - Integration period multiple of line period.
// - Rundown ceiling twice the integration count.
// - Offset nulling is the idle phase.
// - Time rundown from line change to fall.
// - Comparator high in residue: null at once.
module dsps_sequencer #(
  parameter int unsigned INT_CYCLES = `DSPS_INT_MS * `DSPS_NS_PER_MS / `DSPS_CLK_NS,
  parameter int unsigned AZ_CYCLES  = INT_CYCLES
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          startReq,
  input  wire logic          zeroCrossOut,
  output dsps_pkg::dsps_phase_t  phaseLines,
  output logic                   busy,
  output logic                   resultValid,
  output dsps_pkg::dsps_result_t result
);

  // Last cycle of each timed phase, and the rundown ceiling
  localparam logic [`DSPS_CNT_W-1:0] AZ_LAST  = `DSPS_CNT_W'(AZ_CYCLES - 1);
  localparam logic [`DSPS_CNT_W-1:0] INT_LAST = `DSPS_CNT_W'(INT_CYCLES - 1);
  localparam logic [`DSPS_CNT_W-1:0] RUN_LAST = `DSPS_CNT_W'(`DSPS_RUN_MULT * INT_CYCLES - 1);
  localparam logic [`DSPS_CNT_W-1:0] SYNC_LAT = `DSPS_CNT_W'(`DSPS_SYNC_LAT);

  // Reset release pipeline
  logic rstPipeReg;
  logic rstSyncN;

  // Comparator path
  logic compSync;      // Comparator level after two flops
  logic compPrevReg;   // Previous synchronised level
  logic compPrevNext;
  logic fallEdge;      // High-to-low transition seen this cycle

  // Timer
  logic [`DSPS_CNT_W-1:0] count;
  logic                   cntClear;

  // Sequencer state group
  dsps_pkg::dsps_state_t stateReg;
  dsps_pkg::dsps_state_t stateNext;
  dsps_pkg::dsps_phase_t phaseReg;
  dsps_pkg::dsps_phase_t phaseNext;
  logic                  busyReg;
  logic                  busyNext;

  // Result group
  logic                   signReg;     // Sign caught at the end of integration
  logic                   signNext;
  dsps_pkg::dsps_result_t resultReg;
  dsps_pkg::dsps_result_t resultNext;
  logic                   validReg;
  logic                   validNext;

  // Reset asserts at once and releases after two clean edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstPipeReg <= 1'b0;
      rstSyncN   <= 1'b0;
    end else begin
      rstPipeReg <= 1'b1;
      rstSyncN   <= rstPipeReg;
    end
  end

  // Comparator pin is asynchronous to the host clock
  dsps_sync u_comp_sync (
    .clk      (clk),
    .rstSyncN (rstSyncN),
    .asyncIn  (zeroCrossOut),
    .syncOut  (compSync)
  );

  // Edge detector looks only at the synchronised copy
  assign fallEdge = compPrevReg & ~compSync;

  // Timer restarts whenever the phase changes, so each phase after nulling is timed from its line change, and nulling from the start request
  assign cntClear = (stateNext != stateReg) || (stateReg == dsps_pkg::ST_IDLE);

  dsps_cnt u_timer (
    .clk      (clk),
    .rstSyncN (rstSyncN),
    .clear    (cntClear),
    .enable   (1'b1),
    .count    (count)
  );

  // Next state, phase code and busy flag
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      // Idle sits in offset nulling; comparator is not looked at here
      dsps_pkg::ST_IDLE: begin
        if (startReq) begin
          stateNext = dsps_pkg::ST_NULL;
        end
      end
      // Timed nulling before each conversion, comparator still ignored
      dsps_pkg::ST_NULL: begin
        if (count == AZ_LAST) begin
          stateNext = dsps_pkg::ST_INT;
        end
      end
      // Fixed integration, then straight into rundown
      dsps_pkg::ST_INT: begin
        if (count == INT_LAST) begin
          stateNext = dsps_pkg::ST_RUN;
        end
      end
      // Rundown ends on the crossing or at the ceiling
      dsps_pkg::ST_RUN: begin
        if (fallEdge || (count == RUN_LAST)) begin
          stateNext = dsps_pkg::ST_RES;
        end
      end
      // Residue clearing held until the comparator is high again
      // The first cycles still carry the rundown level through the synchroniser, so they are not trusted
      dsps_pkg::ST_RES: begin
        if (compSync && (count > SYNC_LAT)) begin
          stateNext = dsps_pkg::ST_IDLE;
        end
      end
      default: begin
        stateNext = dsps_pkg::ST_IDLE;
      end
    endcase

    // Lines are unlatched at the device, so they are held for the whole phase
    case (stateNext)
      dsps_pkg::ST_INT: begin
        phaseNext = `DSPS_CODE_INT;
      end
      dsps_pkg::ST_RUN: begin
        phaseNext = `DSPS_CODE_RUN;
      end
      dsps_pkg::ST_RES: begin
        phaseNext = `DSPS_CODE_RES;
      end
      default: begin
        phaseNext = `DSPS_CODE_NULL;
      end
    endcase
    busyNext = (stateNext != dsps_pkg::ST_IDLE);
  end

  // Register state and the lines together, so they never disagree
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      stateReg <= dsps_pkg::ST_IDLE;
      phaseReg <= `DSPS_CODE_NULL;
      busyReg  <= 1'b0;
    end else begin
      stateReg <= stateNext;
      phaseReg <= phaseNext;
      busyReg  <= busyNext;
    end
  end

  // Capture sign, magnitude and over-range
  always_comb begin
    compPrevNext = compSync;
    signNext     = signReg;
    resultNext   = resultReg;
    validNext    = 1'b0;
    // Only the last integration cycle is sampled; early readings may chatter
    if ((stateReg == dsps_pkg::ST_INT) && (count == INT_LAST)) begin
      signNext = compSync;
    end
    if (stateReg == dsps_pkg::ST_RUN) begin
      if (fallEdge) begin
        // Count includes the synchroniser delay, so take it back out
        resultNext.magnitude = (count >= SYNC_LAT) ? (count - SYNC_LAT) : '0;
        resultNext.overRange = 1'b0;
        resultNext.sign      = signReg;
      end else if (count == RUN_LAST) begin
        resultNext.magnitude = RUN_LAST;
        resultNext.overRange = 1'b1;
        resultNext.sign      = signReg;
      end
    end
    // Result is announced only once residue clearing is done
    if ((stateReg == dsps_pkg::ST_RES) && compSync && (count > SYNC_LAT)) begin
      validNext = 1'b1;
    end
  end

  // Register the result group
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      compPrevReg <= 1'b1;
      signReg     <= 1'b0;
      resultReg   <= '0;
      validReg    <= 1'b0;
    end else begin
      compPrevReg <= compPrevNext;
      signReg     <= signNext;
      resultReg   <= resultNext;
      validReg    <= validNext;
    end
  end

  // Outputs come straight from flops
  assign phaseLines  = phaseReg;
  assign busy        = busyReg;
  assign resultValid = validReg;
  assign result      = resultReg;

  // Integration is only ever left for rundown
  AST_INT_TO_RUN: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    ($past(phaseReg) == `DSPS_CODE_INT) && (phaseReg != `DSPS_CODE_INT) |-> (phaseReg == `DSPS_CODE_RUN))
    else $error("integration left for a phase other than rundown");

  // Rundown is only ever left for residue clearing
  AST_RUN_TO_RES: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    ($past(phaseReg) == `DSPS_CODE_RUN) && (phaseReg != `DSPS_CODE_RUN) |-> (phaseReg == `DSPS_CODE_RES))
    else $error("rundown not followed by residue clearing");

  // Residue clearing exits one cycle after the comparator is high, into nulling
  AST_RES_EXIT: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    (stateReg == dsps_pkg::ST_RES) && compSync && (count > SYNC_LAT)
      |=> (phaseReg == `DSPS_CODE_NULL) && resultValid)
    else $error("residue clearing not ended at once");

  // Residue clearing is held while the comparator is low
  AST_RES_HOLD: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    (stateReg == dsps_pkg::ST_RES) && (!compSync || (count <= SYNC_LAT)) |=> (phaseReg == `DSPS_CODE_RES))
    else $error("residue clearing left while comparator low");

  // Integration is timed from a cleared timer
  AST_INT_LENGTH: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    $rose(stateReg == dsps_pkg::ST_INT) |-> (count == '0))
    else $error("integration did not start from a cleared timer");

  // Integration is never cut short before its last cycle
  AST_INT_HOLD: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    (stateReg == dsps_pkg::ST_INT) && (count != INT_LAST) |=> (stateReg == dsps_pkg::ST_INT))
    else $error("integration ended before its fixed count");

  // The last integration cycle hands over to rundown at once
  AST_INT_EXIT: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    (stateReg == dsps_pkg::ST_INT) && (count == INT_LAST) |=> (phaseReg == `DSPS_CODE_RUN))
    else $error("integration overran its fixed count");

  // Sign is the synchronised comparator at the last integration cycle
  AST_SIGN_CAPTURE: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    (stateReg == dsps_pkg::ST_INT) && (count == INT_LAST) |=> (signReg == $past(compSync)))
    else $error("sign not taken at end of integration");

  // Magnitude is the rundown count less the synchroniser delay
  AST_MAGNITUDE: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    (stateReg == dsps_pkg::ST_RUN) && fallEdge && (count >= SYNC_LAT)
      |=> (result.magnitude == $past(count) - SYNC_LAT) && !result.overRange)
    else $error("rundown magnitude wrong");

  // Reaching the ceiling without a crossing reports over range
  AST_OVER_RANGE: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    (stateReg == dsps_pkg::ST_RUN) && (count == RUN_LAST) && !fallEdge
      |=> result.overRange && (phaseReg == `DSPS_CODE_RES))
    else $error("over range not reported at rundown ceiling");

  // Comparator is not consulted while nulling: the timer alone ends it
  AST_NULL_TIMED: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    (stateReg == dsps_pkg::ST_NULL) && (count != AZ_LAST) |=> (stateReg == dsps_pkg::ST_NULL))
    else $error("offset nulling left early");

  // A start request in idle moves to null on the next cycle, with busy raised
  AST_ORDER_START: assert property (
    @(posedge clk) disable iff (!rstSyncN)
    (stateReg == dsps_pkg::ST_IDLE) && startReq |=> (stateReg == dsps_pkg::ST_NULL) && busy)
    else $error("conversion did not begin in offset nulling");

endmodule

/* tb/dsps_front_model.sv */
// Behavioural model of the converter front end that the sequencer drives
`include "dsps_cfg.svh"

module dsps_front_model (
  input  wire logic        clk,
  input  wire logic        lineA,
  input  wire logic        lineB,
  input  wire logic        posInput,
  input  wire logic [15:0] runLen,
  input  wire logic [7:0]  resLen,
  output logic             zeroCrossOut
);
  timeunit 1ns;
  timeprecision 100ps;

  int unsigned phaseCnt;  // Edges seen in the present phase
  logic [1:0]  lastCode;  // Code seen at the previous edge
  logic        wobble;    // Toggling level for an undefined comparator

  // Comparator starts high, as after a settled residue phase
  initial begin
    phaseCnt = 0;
    lastCode = 2'h1;
    wobble = 1'b0;
    zeroCrossOut = 1'b1;
  end

  // Lines decoded live at each edge, nothing is latched; phases in any order the host picks
  always @(posedge clk) begin
    logic [1:0] code;
    code = {lineA, lineB};
    phaseCnt = (code == lastCode) ? phaseCnt + 1 : 1;
    lastCode = code;
    wobble = ~wobble;
    // Comparator answers a little after the edge, like an unclocked output
    #2;
    case (code)
      // Input parked on common, loop closed, level undefined
      `DSPS_CODE_NULL: zeroCrossOut = wobble;
      // Noisy at first, then the input polarity
      `DSPS_CODE_INT: zeroCrossOut = (phaseCnt < 5) ? wobble : posInput;
      // High until the integrator crosses zero, then falls
      `DSPS_CODE_RUN: zeroCrossOut = (phaseCnt < runLen);
      // Overshoot settles after resLen edges
      default: zeroCrossOut = (phaseCnt >= resLen);
    endcase
  end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the dual-slope phase sequencer host controller
`include "dsps_cfg.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned INT_C = 20;  // Short integration for a quick run
  localparam int unsigned AZ_C  = 10;  // Short null phase

  logic                   clk, rstn, startReq, zeroCrossOut, busy, resultValid, posInput;
  logic [15:0]            runLen;
  logic [7:0]             resLen;
  logic [31:0]            seed, v;
  logic [1:0]             prevCode;
  dsps_pkg::dsps_phase_t  phaseLines;
  dsps_pkg::dsps_result_t result;
  int                     error_cnt, compares, phaseLen, lastRes;

  dsps_sequencer #(.INT_CYCLES(INT_C), .AZ_CYCLES(AZ_C)) u_dut (
    .clk(clk), .rstn(rstn), .startReq(startReq), .zeroCrossOut(zeroCrossOut),
    .phaseLines(phaseLines), .busy(busy), .resultValid(resultValid), .result(result));

  dsps_front_model u_front (
    .clk(clk), .lineA(phaseLines.lineA), .lineB(phaseLines.lineB), .posInput(posInput),
    .runLen(runLen), .resLen(resLen), .zeroCrossOut(zeroCrossOut));

  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Only legal successor of each phase code
  function automatic logic [1:0] nextCode(input logic [1:0] c);
    case (c)
      `DSPS_CODE_NULL: nextCode = `DSPS_CODE_INT;
      `DSPS_CODE_INT:  nextCode = `DSPS_CODE_RUN;
      `DSPS_CODE_RUN:  nextCode = `DSPS_CODE_RES;
      default:         nextCode = `DSPS_CODE_NULL;
    endcase
  endfunction

  // Result from commanded polarity and crossing time; ceiling flags over range
  function automatic dsps_pkg::dsps_result_t expResult(input logic pos, input int rl);
    expResult.sign = pos;
    // The crossing is only seen after the synchroniser delay, which must still beat the ceiling
    expResult.overRange = (rl + `DSPS_SYNC_LAT >= 2 * INT_C);
    expResult.magnitude = (rl + `DSPS_SYNC_LAT >= 2 * INT_C) ? `DSPS_CNT_W'(2 * INT_C - 1) : `DSPS_CNT_W'(rl);
  endfunction

  // Phase order and integration length watched on the wire
  always @(posedge clk) begin
    if (!rstn) begin
      prevCode = 2'h1;
      phaseLen = 0;
    end else if (phaseLines !== prevCode) begin
      check(phaseLines, nextCode(prevCode));
      if (prevCode == `DSPS_CODE_INT) check(phaseLen, INT_C);
      if (prevCode == `DSPS_CODE_RES) lastRes = phaseLen;
      prevCode = phaseLines;
      phaseLen = 1;
    end else begin
      phaseLen++;
    end
  end

  // One conversion with a stray request while busy
  task automatic convert(input logic pos, input int rl, input int rs);
    dsps_pkg::dsps_result_t exp;
    int n;
    posInput = pos;
    runLen = 16'(rl);
    resLen = 8'(rs);
    exp = expResult(pos, rl);
    startReq = 1'b1;
    @(negedge clk);
    startReq = 1'b0;
    n = 0;
    // Bounded wait for the result pulse
    while (resultValid !== 1'b1 && n < 5000) begin
      @(negedge clk);
      startReq = (n == 30);
      n++;
    end
    if (n >= 5000) begin
      error_cnt++;
      complete_run();
    end
    check(result, exp);
    @(negedge clk);
    check(resultValid, 1'b0);
    check({phaseLines, busy}, 3'h2);
    // Residue lasts until the high level clears the synchroniser, plus the model's one-edge response
    check(lastRes, rs + `DSPS_SYNC_LAT + 1);
    $display("test done: pos=%0b run=%0d res=%0d", pos, rl, rs);
  endtask

  initial begin
    seed = 32'h09bea63e;
    rstn = 1'b0;
    startReq = 1'b0;
    posInput = 1'b1;
    runLen = 16'h000A;
    resLen = 8'h02;
    error_cnt = 0;
    compares = 0;
    lastRes = 0;
    repeat (3) @(negedge clk);
    check({phaseLines, busy, resultValid, result}, 32'h10000000);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    // Corner cases: shortest rundown, both polarities, over range
    convert(1'b1, 4, 1);
    convert(1'b0, 4, 1);
    convert(1'b1, 1000, 3);
    convert(1'b0, 1000, 3);
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      convert(v[0], 4 + int'(v[8:1] % 27), 1 + int'(v[12:10]));
    end
    // Reset in mid conversion returns the lines to null at once
    startReq = 1'b1;
    @(negedge clk);
    startReq = 1'b0;
    repeat (15) @(negedge clk);
    rstn = 1'b0;
    #1;
    check({phaseLines, busy, resultValid, result}, 32'h10000000);
    $display("test done: reset in mid conversion");
    @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    convert(1'b1, 7, 2);
    complete_run();
  end
endmodule
